// ==== mdm_defines.svh ====
// Constants for the management serial link: field codes, register
// offsets, bit positions and timing counts. Included by both ends,
// the host and the device.
`ifndef MDM_DEFINES_SVH
`define MDM_DEFINES_SVH
`define MDM_START 2'b01
`define MDM_OP_RD 2'b10
`define MDM_OP_WR 2'b01
`define MDM_TA_WR 2'b10
`define MDM_HDR_BITS 12
`define MDM_DATA_BITS 16
`define MDM_REG_MMDCTL 5'h0D
`define MDM_REG_MMDAD 5'h0E
`define MDM_REG_EECTL 5'h10
`define MDM_MMD_EEE 5'h03
`define MDM_MMD_AN 5'h07
`define MDM_MMD_EE 5'h1E
`define MDM_MMD_INT 5'h1F
`define MDM_FN_ADDR 2'b00
`define MDM_FN_HI 15
`define MDM_FN_LO 14
`define MDM_EE_BUSY_BIT 0
`define MDM_EE_WR_BIT 1
`define MDM_EE_PRES_BIT 2
`define MDM_HALF_DIV 4
`define MDM_PRE_LEN 32
`endif

// ==== mdm_dev.sv ====
// Device end: frame decoder on the link clock, register space with
// indirect MMD access, EEPROM single-byte handshake to the system clock.
// Assumes an EEPROM engine on mclk answers eeStart with one eeDone pulse.
`timescale 1ns/1ps
`include "mdm_defines.svh"
module mdm_dev
    import mdm_pkg::*;
(
    // Management link
    mdm_if.dev link,
    // System clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Static strap
    input wire logic [4:0] strapAddr,
    // EEPROM engine side
    input wire logic eePresent,
    input wire logic eeDone,
    input wire logic [7:0] eeRdata,
    output logic eeStart,
    output logic eeWrite,
    output logic [15:0] eeAddr,
    output logic [7:0] eeWdata
);
    localparam int HB = `MDM_HDR_BITS;
    localparam int DB = `MDM_DATA_BITS;

    mdm_dst_t state_ff;
    logic [4:0] cnt_ff;
    logic [11:0] hdr_ff;
    logic [11:0] nxt_hdr;
    logic hdrDone;
    logic hit_ff;
    logic rdOp_ff;
    logic [4:0] regAd_ff;
    logic [15:0] shift_ff;
    logic [15:0] wrShift_ff;
    logic [15:0] rdMux;
    logic [15:0] dataRd;
    logic mdioOut_ff;
    logic mdioOe_ff;
    logic commit;
    logic [15:0] wrWord;
    logic [15:0] regFile_ff [32];
    logic [15:0] mmdCtl_ff;
    logic [15:0] mmdAd_ff;
    logic [15:0] mmdStore_ff [3];
    logic [1:0] knownIdx;
    logic known;
    logic isData;
    logic eeBusy_ff;
    logic eeWr_ff;
    logic [15:0] eeAddrHold_ff;
    logic [7:0] eeWbuf_ff;
    logic [7:0] eeWdHold_ff;
    logic [7:0] eeRd_ff;
    logic reqTgl_ff;
    logic eeGo;
    logic [2:0] ackSync_ff;
    logic ackSeen_ff;
    logic ackEv;
    logic [2:0] presSync_ff;
    logic presLvl_ff;
    logic [2:0] reqSync_ff;
    logic reqSeen_ff;
    logic reqEv;
    logic ackTgl_ff;
    logic [7:0] rdHold_ff;
    logic eeStart_ff;
    logic eeWrite_ff;
    logic [15:0] eeAddr_ff;
    logic [7:0] eeWdata_ff;

    // driver stays off except for the second turnaround bit and read data
    assign link.devOut = mdioOut_ff;
    assign link.devOe = mdioOe_ff;
    assign eeStart = eeStart_ff;
    assign eeWrite = eeWrite_ff;
    assign eeAddr = eeAddr_ff;
    assign eeWdata = eeWdata_ff;

    assign nxt_hdr = {hdr_ff[10:0], link.mdio};
    assign hdrDone = (state_ff == MDM_D_HDR) && (cnt_ff == 5'(HB - 1));
    assign wrWord = {wrShift_ff[14:0], link.mdio};
    // only a matched write frame commits
    assign commit = (state_ff == MDM_D_DATA) && (cnt_ff == 5'(DB - 1)) && hit_ff && !rdOp_ff;
    assign isData = mmdCtl_ff[`MDM_FN_HI:`MDM_FN_LO] != `MDM_FN_ADDR;

    // the whole frame logic runs on the host-driven clock
    // any run of ones, then 0 then 1 opens a frame
    always_ff @(posedge link.mdc or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= MDM_D_IDLE;
            cnt_ff <= 5'h00;
            hdr_ff <= 12'h000;
        end else begin
            case (state_ff)
                MDM_D_IDLE: begin
                    if (!link.mdio) begin
                        state_ff <= MDM_D_START;
                    end
                end
                MDM_D_START: begin
                    if (link.mdio) begin
                        state_ff <= MDM_D_HDR;
                        cnt_ff <= 5'h00;
                    end
                end
                MDM_D_HDR: begin
                    hdr_ff <= nxt_hdr;
                    cnt_ff <= cnt_ff + 5'h01;
                    if (hdrDone) begin
                        state_ff <= MDM_D_TA;
                        cnt_ff <= 5'h00;
                    end
                end
                MDM_D_TA: begin
                    cnt_ff <= cnt_ff + 5'h01;
                    if (cnt_ff == 5'h01) begin
                        state_ff <= MDM_D_DATA;
                        cnt_ff <= 5'h00;
                    end
                end
                MDM_D_DATA: begin
                    cnt_ff <= cnt_ff + 5'h01;
                    if (cnt_ff == 5'(DB - 1)) begin
                        state_ff <= MDM_D_IDLE;
                    end
                end
                default: begin
                    state_ff <= MDM_D_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge link.mdc or negedge rst_n) begin
        if (!rst_n) begin
            hit_ff <= 1'b0;
            rdOp_ff <= 1'b0;
            regAd_ff <= 5'h00;
        end else if (hdrDone) begin
            hit_ff <= (nxt_hdr[9:5] == strapAddr) &&
                      ((nxt_hdr[11:10] == `MDM_OP_RD) || (nxt_hdr[11:10] == `MDM_OP_WR));
            rdOp_ff <= nxt_hdr[11:10] == `MDM_OP_RD;
            regAd_ff <= nxt_hdr[4:0];
        end
    end

    always_comb begin
        known = 1'b1;
        knownIdx = 2'd0;
        case (mmdCtl_ff[4:0])
            `MDM_MMD_EEE: knownIdx = 2'd0;
            `MDM_MMD_AN: knownIdx = 2'd1;
            `MDM_MMD_INT: knownIdx = 2'd2;
            default: known = 1'b0;
        endcase
    end

    // indirect data path; unused MMDs read zero
    always_comb begin
        if (mmdCtl_ff[4:0] == `MDM_MMD_EE) begin
            dataRd = {8'h00, eeRd_ff};
        end else if (known) begin
            dataRd = mmdStore_ff[knownIdx];
        end else begin
            dataRd = 16'h0000;
        end
        case (nxt_hdr[4:0])
            `MDM_REG_MMDCTL: rdMux = mmdCtl_ff;
            `MDM_REG_MMDAD: rdMux = isData ? dataRd : mmdAd_ff;
            `MDM_REG_EECTL: rdMux = {13'h0000, presLvl_ff, eeWr_ff, eeBusy_ff};
            default: rdMux = regFile_ff[nxt_hdr[4:0]];
        endcase
    end

    // zero in second turnaround bit, then MSB first
    always_ff @(posedge link.mdc or negedge rst_n) begin
        if (!rst_n) begin
            mdioOe_ff <= 1'b0;
            mdioOut_ff <= 1'b1;
            shift_ff <= 16'h0000;
        end else if (hdrDone) begin
            shift_ff <= rdMux;
        end else if (state_ff == MDM_D_TA && cnt_ff == 5'h00) begin
            mdioOe_ff <= hit_ff && rdOp_ff;
            mdioOut_ff <= 1'b0;
        end else if (mdioOe_ff && state_ff == MDM_D_DATA && cnt_ff == 5'(DB - 1)) begin
            mdioOe_ff <= 1'b0;
            mdioOut_ff <= 1'b1;
        end else if (mdioOe_ff) begin
            mdioOut_ff <= shift_ff[15];
            shift_ff <= {shift_ff[14:0], 1'b0};
        end
    end

    always_ff @(posedge link.mdc or negedge rst_n) begin
        if (!rst_n) begin
            wrShift_ff <= 16'h0000;
        end else if (state_ff == MDM_D_DATA) begin
            wrShift_ff <= wrWord;
        end
    end

    // plain storage for the other direct registers
    always_ff @(posedge link.mdc or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) begin
                regFile_ff[i] <= 16'h0000;
            end
        end else if (commit && regAd_ff != `MDM_REG_MMDCTL &&
                     regAd_ff != `MDM_REG_MMDAD && regAd_ff != `MDM_REG_EECTL) begin
            regFile_ff[regAd_ff] <= wrWord;
        end
    end

    // function/device select, then address or data
    always_ff @(posedge link.mdc or negedge rst_n) begin
        if (!rst_n) begin
            mmdCtl_ff <= 16'h0000;
            mmdAd_ff <= 16'h0000;
        end else if (commit && regAd_ff == `MDM_REG_MMDCTL) begin
            mmdCtl_ff <= wrWord;
        end else if (commit && regAd_ff == `MDM_REG_MMDAD && !isData) begin
            mmdAd_ff <= wrWord;
        end
    end

    // data words of EEE, autoneg and internal devices
    always_ff @(posedge link.mdc or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                mmdStore_ff[i] <= 16'h0000;
            end
        end else if (commit && regAd_ff == `MDM_REG_MMDAD && isData && known) begin
            mmdStore_ff[knownIdx] <= wrWord;
        end
    end

    // write byte staged, frozen while busy
    always_ff @(posedge link.mdc or negedge rst_n) begin
        if (!rst_n) begin
            eeWbuf_ff <= 8'h00;
        end else if (commit && regAd_ff == `MDM_REG_MMDAD && isData &&
                     mmdCtl_ff[4:0] == `MDM_MMD_EE && !eeBusy_ff) begin
            eeWbuf_ff <= wrWord[7:0];
        end
    end

    // start only when idle and device 1E selected
    assign eeGo = commit && regAd_ff == `MDM_REG_EECTL && wrWord[`MDM_EE_BUSY_BIT] &&
                  !eeBusy_ff && mmdCtl_ff[4:0] == `MDM_MMD_EE;

    // one byte per request, busy until done
    always_ff @(posedge link.mdc or negedge rst_n) begin
        if (!rst_n) begin
            eeBusy_ff <= 1'b0;
            eeWr_ff <= 1'b0;
            eeAddrHold_ff <= 16'h0000;
            eeWdHold_ff <= 8'h00;
            eeRd_ff <= 8'h00;
            reqTgl_ff <= 1'b0;
        end else if (eeGo) begin
            eeBusy_ff <= 1'b1;
            eeWr_ff <= wrWord[`MDM_EE_WR_BIT];
            eeAddrHold_ff <= mmdAd_ff;
            eeWdHold_ff <= eeWbuf_ff;
            reqTgl_ff <= ~reqTgl_ff;
        end else if (ackEv) begin
            eeBusy_ff <= 1'b0;
            if (!eeWr_ff) begin
                eeRd_ff <= rdHold_ff;
            end
        end
    end

    // Done toggle and present level into the link domain
    assign ackEv = (ackSync_ff[1] == ackSync_ff[2]) && (ackSync_ff[2] != ackSeen_ff);
    always_ff @(posedge link.mdc or negedge rst_n) begin
        if (!rst_n) begin
            ackSync_ff <= 3'h0;
            ackSeen_ff <= 1'b0;
            presSync_ff <= 3'h0;
            presLvl_ff <= 1'b0;
        end else begin
            ackSync_ff <= {ackSync_ff[1:0], ackTgl_ff};
            presSync_ff <= {presSync_ff[1:0], eePresent};
            if (ackEv) begin
                ackSeen_ff <= ackSync_ff[2];
            end
            // present flag follows the engine's detection
            if (presSync_ff[1] == presSync_ff[2]) begin
                presLvl_ff <= presSync_ff[2];
            end
        end
    end

    // Request toggle into the system domain; held fields stay stable while busy
    assign reqEv = (reqSync_ff[1] == reqSync_ff[2]) && (reqSync_ff[2] != reqSeen_ff);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reqSync_ff <= 3'h0;
            reqSeen_ff <= 1'b0;
            eeStart_ff <= 1'b0;
            eeWrite_ff <= 1'b0;
            eeAddr_ff <= 16'h0000;
            eeWdata_ff <= 8'h00;
        end else begin
            reqSync_ff <= {reqSync_ff[1:0], reqTgl_ff};
            eeStart_ff <= reqEv;
            if (reqEv) begin
                reqSeen_ff <= reqSync_ff[2];
                eeWrite_ff <= eeWr_ff;
                eeAddr_ff <= eeAddrHold_ff;
                eeWdata_ff <= eeWdHold_ff;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ackTgl_ff <= 1'b0;
            rdHold_ff <= 8'h00;
        end else if (eeDone) begin
            ackTgl_ff <= ~ackTgl_ff;
            rdHold_ff <= eeRdata;
        end
    end
endmodule : mdm_dev

// ==== mdm_host.sv ====
// Host end: makes MDC by dividing mclk and runs one read or write
// frame per accepted command. Needs PRE_LEN >= 1 and HALF_DIV >= 3 (line sync delay).
`timescale 1ns/1ps
`include "mdm_defines.svh"
module mdm_host
    import mdm_pkg::*;
#(
    parameter int HALF_DIV = `MDM_HALF_DIV,
    parameter int PRE_LEN = `MDM_PRE_LEN
) (
    // Management link
    mdm_if.host link,
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Command
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic cmdWrite,
    input wire logic [4:0] cmdPhy,
    input wire logic [4:0] cmdReg,
    input wire logic [15:0] cmdWdata,
    // Response
    output logic respValid,
    output logic [15:0] respRdata
);
    localparam int LAST = PRE_LEN + 31;

    mdm_hst_t state_ff;
    logic [7:0] divCnt_ff;
    logic mdc_ff;
    logic [7:0] bitCnt_ff;
    logic [7:0] nxt_bitCnt;
    logic [31:0] tx_ff;
    logic rdOp_ff;
    logic out_ff;
    logic oe_ff;
    logic [2:0] inSync_ff;
    logic inLvl_ff;
    logic [15:0] rx_ff;
    logic ready_ff;
    logic resp_ff;
    logic [15:0] respData_ff;
    logic wrap;
    logic rise;
    logic fall;

    assign link.mdc = mdc_ff;
    assign link.hostOut = out_ff;
    assign link.hostOe = oe_ff;
    assign cmdReady = ready_ff;
    assign respValid = resp_ff;
    assign respRdata = respData_ff;
    assign wrap = (state_ff == MDM_H_RUN) && (divCnt_ff == 8'(HALF_DIV - 1));
    assign rise = wrap && !mdc_ff;
    assign fall = wrap && mdc_ff;
    assign nxt_bitCnt = bitCnt_ff + 8'h01;

    // clock made here, low between frames
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_ff <= 8'h00;
            mdc_ff <= 1'b0;
        end else if (state_ff != MDM_H_RUN) begin
            divCnt_ff <= 8'h00;
            mdc_ff <= 1'b0;
        end else if (wrap) begin
            divCnt_ff <= 8'h00;
            mdc_ff <= ~mdc_ff;
        end else begin
            divCnt_ff <= divCnt_ff + 8'h01;
        end
    end

    // Line sampled through three flops, accepted when two agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            inSync_ff <= 3'h7;
            inLvl_ff <= 1'b1;
        end else begin
            inSync_ff <= {inSync_ff[1:0], link.mdio};
            if (inSync_ff[1] == inSync_ff[2]) begin
                inLvl_ff <= inSync_ff[2];
            end
        end
    end

    // preamble, start, opcode, turnaround, MSB first
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= MDM_H_IDLE;
            ready_ff <= 1'b1;
            resp_ff <= 1'b0;
            bitCnt_ff <= 8'h00;
            tx_ff <= 32'h0000_0000;
            rdOp_ff <= 1'b0;
            out_ff <= 1'b1;
            oe_ff <= 1'b0;
        end else begin
            resp_ff <= 1'b0;
            if (state_ff == MDM_H_IDLE) begin
                if (cmdValid && ready_ff) begin
                    state_ff <= MDM_H_RUN;
                    ready_ff <= 1'b0;
                    bitCnt_ff <= 8'h00;
                    rdOp_ff <= !cmdWrite;
                    tx_ff <= {`MDM_START, cmdWrite ? `MDM_OP_WR : `MDM_OP_RD, cmdPhy, cmdReg,
                              cmdWrite ? `MDM_TA_WR : 2'b11, cmdWrite ? cmdWdata : 16'h0000};
                    out_ff <= 1'b1;
                    oe_ff <= 1'b1;
                end
            end else if (fall) begin
                if (bitCnt_ff == 8'(LAST)) begin
                    state_ff <= MDM_H_IDLE;
                    ready_ff <= 1'b1;
                    resp_ff <= 1'b1;
                    out_ff <= 1'b1;
                    oe_ff <= 1'b0;
                end else begin
                    bitCnt_ff <= nxt_bitCnt;
                    if (nxt_bitCnt >= 8'(PRE_LEN)) begin
                        out_ff <= tx_ff[31];
                        tx_ff <= {tx_ff[30:0], 1'b0};
                    end else begin
                        out_ff <= 1'b1;
                    end
                    // host lets go from first turnaround bit of a read
                    oe_ff <= !(rdOp_ff && nxt_bitCnt >= 8'(PRE_LEN + 14));
                end
            end
        end
    end

    // read data captured on rising MDC
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_ff <= 16'h0000;
            respData_ff <= 16'h0000;
        end else begin
            if (rise && rdOp_ff && bitCnt_ff >= 8'(PRE_LEN + 16)) begin
                rx_ff <= {rx_ff[14:0], inLvl_ff};
            end
            if (fall && bitCnt_ff == 8'(LAST)) begin
                respData_ff <= rdOp_ff ? rx_ff : 16'h0000;
            end
        end
    end
endmodule : mdm_host

// ==== mdm_if.sv ====
// Two-pin management link between host and device.
// Resolves the shared data line; undriven line reads as pulled-up one.
`timescale 1ns/1ps
interface mdm_if;
    logic mdc;
    logic hostOut;
    logic hostOe;
    logic devOut;
    logic devOe;
    logic mdio;
    // Pull-up wins when nobody drives
    assign mdio = hostOe ? hostOut : (devOe ? devOut : 1'b1);
    modport host(output mdc, output hostOut, output hostOe, input mdio);
    modport dev(input mdc, output devOut, output devOe, input mdio);
endinterface : mdm_if

// ==== mdm_link_chk.sv ====
// Checker for the wires of the management link between both ends.
// Assumes it watches the interface joining the host end to the device end.
`timescale 1ns/1ps
module mdm_link_chk #(
    parameter logic [4:0] PHY_ADDR = 5'h05
) (
    // Clocks and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Link signals
    input wire logic mdc,
    input wire logic hostOut,
    input wire logic hostOe,
    input wire logic devOut,
    input wire logic devOe,
    input wire logic mdio
);
    logic [14:0] lineHist_ff;
    logic [5:0] driveCnt_ff;

    always_ff @(posedge mdc or negedge rst_n) begin
        if (!rst_n) begin
            lineHist_ff <= '0;
        end else begin
            lineHist_ff <= {lineHist_ff[13:0], mdio};
        end
    end

    // Counts sampled edges with the device driving
    always_ff @(posedge mdc or negedge rst_n) begin
        if (!rst_n) begin
            driveCnt_ff <= '0;
        end else begin
            driveCnt_ff <= devOe ? driveCnt_ff + 6'h01 : 6'h00;
        end
    end

    // Four preamble ones, then start 01 and write code 01
    sequence wrHeadSeq;
        (hostOe && mdio) [*4] ##1 (hostOe && !mdio) ##1 (hostOe && mdio)
            ##1 (hostOe && !mdio) ##1 (hostOe && mdio);
    endsequence
    sequence quietSeq;
        (!devOe) [*8] ##1 (!devOe) [*8] ##1 (!devOe) [*8];
    endsequence

    AST_WR_NO_DRIVE: assert property (
        @(posedge mdc) disable iff (!rst_n) wrHeadSeq |=> quietSeq)
        else $error("device drove the line in a write frame");
    AST_READ_HDR: assert property (
        @(posedge mdc) disable iff (!rst_n) $rose(devOe) |->
        lineHist_ff[14:11] == 4'h6 && lineHist_ff[10:6] == PHY_ADDR && lineHist_ff[0])
        else $error("device drive without matching read header");
    AST_TA_ZERO: assert property (
        @(posedge mdc) disable iff (!rst_n) $rose(devOe) |-> !devOut && !mdio)
        else $error("second turnaround bit not zero");
    AST_HOST_RELEASE: assert property (
        @(posedge mdc) disable iff (!rst_n) $rose(devOe) |-> !hostOe && !$past(hostOe))
        else $error("host still driving at turnaround");
    AST_DRIVE_LEN: assert property (
        @(posedge mdc) disable iff (!rst_n) $fell(devOe) |-> driveCnt_ff == 6'h11)
        else $error("device drive not turnaround plus sixteen bits");
    AST_NO_CONTENTION: assert property (
        @(posedge mclk) disable iff (!rst_n) !(hostOe && devOe))
        else $error("both ends drive the line");
    // Assumes a host half period of at least two mclk cycles
    AST_MDC_HALF: assert property (
        @(posedge mclk) disable iff (!rst_n) $changed(mdc) |=> $stable(mdc))
        else $error("link clock half period too short");
    // Low clock longer than a half period (under eight mclk) means idle
    AST_IDLE_RELEASED: assert property (
        @(posedge mclk) disable iff (!rst_n) (!mdc && !hostOe) [*8] |-> !devOe)
        else $error("device drives an idle line");
endmodule : mdm_link_chk

// ==== mdm_pkg.sv ====
// Types shared by both ends of the management serial link.
// Assumes the constants header is on the include path.
package mdm_pkg;
    typedef enum logic [2:0] {
        MDM_D_IDLE = 3'b000,
        MDM_D_START = 3'b001,
        MDM_D_HDR = 3'b010,
        MDM_D_TA = 3'b011,
        MDM_D_DATA = 3'b100
    } mdm_dst_t;
    typedef enum logic [0:0] {
        MDM_H_IDLE = 1'b0,
        MDM_H_RUN = 1'b1
    } mdm_hst_t;
endpackage : mdm_pkg

// ==== tb_top.sv ====
// Bench joining host and device ends over the link interface.
// Assumes a small responder here stands in for the EEPROM engine.
`timescale 1ns/1ps
module tb_top;
    localparam logic [4:0] PHY = 5'h05;
    localparam logic [4:0] OTHER = 5'h0A;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cmdValid = 1'b0;
    logic cmdWrite = 1'b0;
    logic [4:0] cmdPhy = 5'h00;
    logic [4:0] cmdReg = 5'h00;
    logic [15:0] cmdWdata = 16'h0000;
    logic cmdReady, respValid, eeStart, eeWrite, seenWr;
    logic [15:0] respRdata, eeAddr, capWord, rd, seenAddr;
    logic [7:0] eeWdata, seenData;
    logic eeDone = 1'b0;
    logic [7:0] eeRdata = 8'h00;
    logic [4:0] regList [4] = '{5'h00, 5'h0F, 5'h11, 5'h1F};
    logic [4:0] devList [4] = '{5'h03, 5'h07, 5'h1F, 5'h05};
    int startCnt = 0;
    int eeWait = 0;
    int errorCnt = 0;
    int totalChecks = 0;

    initial begin
        forever #5 mclk = ~mclk;
    end

    mdm_if i_mdm_if ();
    mdm_host #(.HALF_DIV(4), .PRE_LEN(32)) i_mdm_host (.link(i_mdm_if.host), .mclk(mclk),
        .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite),
        .cmdPhy(cmdPhy), .cmdReg(cmdReg), .cmdWdata(cmdWdata), .respValid(respValid),
        .respRdata(respRdata));
    mdm_dev i_mdm_dev (.link(i_mdm_if.dev), .mclk(mclk), .rst_n(rst_n), .strapAddr(PHY),
        .eePresent(1'b1), .eeDone(eeDone), .eeRdata(eeRdata), .eeStart(eeStart),
        .eeWrite(eeWrite), .eeAddr(eeAddr), .eeWdata(eeWdata));
    mdm_link_chk #(.PHY_ADDR(PHY)) i_mdm_link_chk (.mclk(mclk), .rst_n(rst_n),
        .mdc(i_mdm_if.mdc), .hostOut(i_mdm_if.hostOut), .hostOe(i_mdm_if.hostOe),
        .devOut(i_mdm_if.devOut), .devOe(i_mdm_if.devOe), .mdio(i_mdm_if.mdio));

    // Slow engine so the busy window spans several frames
    always @(posedge mclk) begin
        eeDone <= (eeWait == 1);
        eeRdata <= eeAddr[7:0] ^ 8'h3C;
        eeWait <= eeStart ? 2000 : (eeWait > 0 ? eeWait - 1 : 0);
        if (eeStart) begin
            startCnt <= startCnt + 1;
            seenAddr <= eeAddr;
            seenData <= eeWdata;
            seenWr <= eeWrite;
        end
    end

    // Bits seen on the wire while the device drives
    always @(posedge i_mdm_if.mdc) begin
        if (i_mdm_if.devOe) begin
            capWord <= {capWord[14:0], i_mdm_if.mdio};
        end
    end

    task automatic endSim();
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : endSim

    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check16

    task automatic xfer(input logic wr, input logic [4:0] phy, input logic [4:0] ra,
        input logic [15:0] wd);
        int n;
        @(posedge mclk);
        cmdValid <= 1'b1;
        cmdWrite <= wr;
        cmdPhy <= phy;
        cmdReg <= ra;
        cmdWdata <= wd;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (cmdReady !== 1'b1 && n < 10);
        if (cmdReady !== 1'b1) begin
            errorCnt++;
            $display("[FAIL] ready expected 1 seen 0");
            endSim();
        end
        @(posedge mclk);
        cmdValid <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (respValid !== 1'b1 && n < 5000);
        if (respValid === 1'b1) begin
            rd = respRdata;
        end else begin
            errorCnt++;
            $display("[FAIL] response expected 1 seen 0");
            endSim();
        end
    endtask : xfer

    task automatic chkRd(input logic [4:0] ra, input logic [15:0] exp, input string what);
        xfer(1'b0, PHY, ra, 16'h0000);
        check16(what, exp, rd);
        check16("wire bits", exp, capWord);
    endtask : chkRd

    task automatic pollIdle();
        int n;
        n = 0;
        do begin
            xfer(1'b0, PHY, 5'h10, 16'h0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
        check16("busy", 16'h0000, {15'h0000, rd[0]});
    endtask : pollIdle

    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (regList[i]) begin
            xfer(1'b1, PHY, regList[i], 16'hA5C3 ^ {11'h000, regList[i]});
        end
        foreach (regList[i]) begin
            chkRd(regList[i], 16'hA5C3 ^ {11'h000, regList[i]}, "direct reg");
        end
        // idle gap lets the line checker see a quiet bus
        repeat (12) @(posedge mclk);
        // Foreign address leaves storage and line alone
        xfer(1'b1, OTHER, 5'h11, 16'hFFFF);
        chkRd(5'h11, 16'hA5C3 ^ 16'h0011, "foreign write");
        xfer(1'b0, OTHER, 5'h11, 16'h0000);
        check16("foreign read", 16'hFFFF, rd);
        // each MMD gets an address then a data word; unused device 05 reads zero
        foreach (devList[i]) begin
            xfer(1'b1, PHY, 5'h0D, {11'h000, devList[i]});
            xfer(1'b1, PHY, 5'h0E, 16'h0040 | {14'h0000, i[1:0]});
            chkRd(5'h0E, 16'h0040 | {14'h0000, i[1:0]}, "mmd address");
            xfer(1'b1, PHY, 5'h0D, 16'h4000 | {11'h000, devList[i]});
            xfer(1'b1, PHY, 5'h0E, 16'h1230 | {14'h0000, i[1:0]});
            chkRd(5'h0E, (devList[i] == 5'h05) ? 16'h0000 :
                16'h1230 | {14'h0000, i[1:0]}, "mmd data");
        end
        xfer(1'b0, PHY, 5'h10, 16'h0000);
        check16("present", 16'h0004, rd & 16'h0005);
        // EEPROM byte write, then a second start while busy
        xfer(1'b1, PHY, 5'h0D, 16'h001E);
        xfer(1'b1, PHY, 5'h0E, 16'h0123);
        xfer(1'b1, PHY, 5'h0D, 16'h401E);
        xfer(1'b1, PHY, 5'h0E, 16'h005A);
        xfer(1'b1, PHY, 5'h10, 16'h0003);
        xfer(1'b1, PHY, 5'h10, 16'h0001);
        xfer(1'b0, PHY, 5'h10, 16'h0000);
        check16("busy set", 16'h0001, {15'h0000, rd[0]});
        pollIdle();
        check16("start count", 16'h0001, startCnt[15:0]);
        check16("ee addr", 16'h0123, seenAddr);
        check16("ee data", 16'h005A, {8'h00, seenData});
        check16("ee dir", 16'h0001, {15'h0000, seenWr});
        // EEPROM byte read
        xfer(1'b1, PHY, 5'h0D, 16'h001E);
        xfer(1'b1, PHY, 5'h0E, 16'h0042);
        xfer(1'b1, PHY, 5'h10, 16'h0001);
        pollIdle();
        xfer(1'b1, PHY, 5'h0D, 16'h401E);
        chkRd(5'h0E, 16'h007E, "ee byte");
        check16("ee read dir", 16'h0042, {seenAddr[15:1], seenWr});
        endSim();
    end
endmodule : tb_top
